// File: rtl/srm_regs.svh
// Port offsets, field layouts, reset values and timing figures
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH

// ==================================================================
// I/O port offsets
`define SRM_PORT_DMA_BASE     16'h0000
`define SRM_PORT_DMA_STAT_LO  16'h0008
`define SRM_PORT_DMA_CLR_FF   16'h000c
`define SRM_PORT_PIC_M_CMD    16'h0020
`define SRM_PORT_PIC_M_DATA   16'h0021
`define SRM_PORT_TMR0         16'h0040
`define SRM_PORT_TMR2         16'h0042
`define SRM_PORT_TMR_CTRL     16'h0043
`define SRM_PORT_RTC_IDX      16'h0070
`define SRM_PORT_PIC_S_CMD    16'h00a0
`define SRM_PORT_PIC_S_DATA   16'h00a1
`define SRM_PORT_SR_CTRL      16'h00b4
`define SRM_PORT_DMA_STAT_HI  16'h00d0

// ==================================================================
// Field positions
`define SRM_SR_CTRL_EN_BIT    0
`define SRM_RTC_NMI_BIT       7
`define SRM_PIC_ICW1_BIT      4
`define SRM_PIC_OP_WORD_3_BIT      3
`define SRM_PIC_SNGL_BIT      1
`define SRM_PIC_IC4_BIT       0
`define SRM_TMR_SEL_HI        7
`define SRM_TMR_SEL_LO        6
`define SRM_DMA_TC_MASK       8'h0f

// ==================================================================
// Readback sequence last indices and reserved-bit handling
`define SRM_PIC_SEQ_LAST      4'hb
`define SRM_TMR_SEQ_LAST      3'h6
`define SRM_IW2_KEEP          8'hf8
`define SRM_IW4_KEEP          8'h12
`define SRM_OW2_KEEP          8'he7
`define SRM_OW3_KEEP          8'h47
`define SRM_OW3_FORCE         8'h08

// ==================================================================
// Reset values
`define SRM_RST_BYTE          8'h00
`define SRM_RST_WORD          16'h0000

// ==================================================================
// Timing
`define SRM_CLK_MHZ           250.0
`define SRM_FAST_TICK_MS      13.5
`define SRM_NORM_TICK_MS      54.6

`endif

// File: rtl/srm_pkg.sv
// Types shared by the save/restore readback logic
`default_nettype none
package srm_pkg;
  // ================================================================
  // Interrupt controller init-word sequence, Gray coded
  typedef enum logic [1:0] {
    SRM_PIC_IDLE = 2'b00,
    SRM_PIC_W2   = 2'b01,
    SRM_PIC_W3   = 2'b11,
    SRM_PIC_W4   = 2'b10
  } srm_pic_st_t;
endpackage : srm_pkg
`default_nettype wire

// File: rtl/srm_pic_shadow.sv
// Shadow copies of one interrupt controller's write-only words
`include "srm_regs.svh"
`default_nettype none
module srm_pic_shadow (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       cmd_wr,
  input  wire logic       data_wr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] iw2,
  output logic      [7:0] iw3,
  output logic      [7:0] iw4,
  output logic      [7:0] ow1,
  output logic      [7:0] ow2,
  output logic      [7:0] ow3
);
  srm_pkg::srm_pic_st_t st_ff, nxt_st;
  logic [7:0] iw2_ff, iw3_ff, iw4_ff, ow1_ff, ow2_ff, ow3_ff;
  logic [7:0] nxt_iw2, nxt_iw3, nxt_iw4, nxt_ow1, nxt_ow2, nxt_ow3;
  logic       sngl_ff, ic4_ff, nxt_sngl, nxt_ic4;

  // ================================================================
  // Init words follow the command word; later data writes are masks
  always_comb begin
    nxt_st   = st_ff;
    nxt_sngl = sngl_ff;
    nxt_ic4  = ic4_ff;
    nxt_iw2  = iw2_ff;
    nxt_iw3  = iw3_ff;
    nxt_iw4  = iw4_ff;
    nxt_ow1  = ow1_ff;
    nxt_ow2  = ow2_ff;
    nxt_ow3  = ow3_ff;
    if (cmd_wr) begin
      if (wdata[`SRM_PIC_ICW1_BIT]) begin
        nxt_sngl = wdata[`SRM_PIC_SNGL_BIT];
        nxt_ic4  = wdata[`SRM_PIC_IC4_BIT];
        nxt_st   = srm_pkg::SRM_PIC_W2;
      end else if (wdata[`SRM_PIC_OP_WORD_3_BIT]) begin
        nxt_ow3 = wdata;
      end else begin
        nxt_ow2 = wdata;
      end
    end else if (data_wr) begin
      case (st_ff)
        srm_pkg::SRM_PIC_W2: begin
          nxt_iw2 = wdata;
          if (!sngl_ff) begin
            nxt_st = srm_pkg::SRM_PIC_W3;
          end else if (ic4_ff) begin
            nxt_st = srm_pkg::SRM_PIC_W4;
          end else begin
            nxt_st = srm_pkg::SRM_PIC_IDLE;
          end
        end
        srm_pkg::SRM_PIC_W3: begin
          nxt_iw3 = wdata;
          nxt_st  = ic4_ff ? srm_pkg::SRM_PIC_W4 : srm_pkg::SRM_PIC_IDLE;
        end
        srm_pkg::SRM_PIC_W4: begin
          nxt_iw4 = wdata;
          nxt_st  = srm_pkg::SRM_PIC_IDLE;
        end
        default: begin
          nxt_ow1 = wdata;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff   <= srm_pkg::SRM_PIC_IDLE;
      sngl_ff <= 1'b0;
      ic4_ff  <= 1'b0;
      iw2_ff  <= `SRM_RST_BYTE;
      iw3_ff  <= `SRM_RST_BYTE;
      iw4_ff  <= `SRM_RST_BYTE;
      ow1_ff  <= `SRM_RST_BYTE;
      ow2_ff  <= `SRM_RST_BYTE;
      ow3_ff  <= `SRM_RST_BYTE;
    end else begin
      st_ff   <= nxt_st;
      sngl_ff <= nxt_sngl;
      ic4_ff  <= nxt_ic4;
      iw2_ff  <= nxt_iw2;
      iw3_ff  <= nxt_iw3;
      iw4_ff  <= nxt_iw4;
      ow1_ff  <= nxt_ow1;
      ow2_ff  <= nxt_ow2;
      ow3_ff  <= nxt_ow3;
    end
  end

  // ================================================================
  // Reserved fields read back as fixed patterns
  assign iw2 = iw2_ff & `SRM_IW2_KEEP;
  assign iw3 = iw3_ff;
  assign iw4 = iw4_ff & `SRM_IW4_KEEP;
  assign ow1 = ow1_ff;
  assign ow2 = ow2_ff & `SRM_OW2_KEEP;
  assign ow3 = (ow3_ff & `SRM_OW3_KEEP) | `SRM_OW3_FORCE
             | {2'b00, ow3_ff[6], 5'h00};
endmodule : srm_pic_shadow
`default_nettype wire

// File: rtl/srm_top.sv
// Save/restore readback and write-back of legacy I/O registers
//
// Summary of operation
// - In the mode, write-only registers read back; ports 20h and 40h step per read.
// - Port 20h returns six master then six slave controller words.
// - Port 40h walks seven reads: counter 0 status/base, counter 2 base.
// - Port 42h read returns counter 2 status in bits 5:0.
// - Port 70h read returns last written clock index in bits 6:0.
// - Controller readback forces reserved fields to fixed values.
// - In the mode, read-only current registers accept writes.
// - Normal writes to base registers also load the current registers.
// - After timer readback and mode exit, system tick runs at 13.5 ms.
// - In the mode, writes to 08h and D0h load DMA status.
`include "srm_regs.svh"
`default_nettype none
module srm_top #(
  parameter int unsigned DMA_CH        = 4,
  parameter int unsigned NORM_TICK_CYC =
    int'(`SRM_NORM_TICK_MS * 1000.0 * `SRM_CLK_MHZ),
  parameter int unsigned FAST_TICK_CYC =
    int'(`SRM_FAST_TICK_MS * 1000.0 * `SRM_CLK_MHZ)
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  input  wire logic [7:0]  dma_status_lo_set,
  input  wire logic [7:0]  dma_status_hi_set,
  output logic             io_rd_claim,
  output logic      [7:0]  io_rdata,
  output logic             io_rd_valid,
  output logic             save_restore_mode,
  output logic             sys_tick,
  output logic             timer_fast
);
  localparam int unsigned NREG = 2 * DMA_CH;

  // ================================================================
  // Elaboration checks
  if (DMA_CH < 1 || DMA_CH > 4) begin : g_bad_ch
    $error("DMA_CH must be 1 to 4");
  end
  if (NORM_TICK_CYC < 2 || NORM_TICK_CYC >= (1 << 24) ||
      FAST_TICK_CYC < 2 || FAST_TICK_CYC >= (1 << 24)) begin : g_bad_tick
    $error("tick periods must fit 2 to 2**24-1 cycles");
  end

  // ================================================================
  // Helpers
  function automatic logic [15:0] set_byte(input logic [15:0] w,
                                           input logic        hi,
                                           input logic [7:0]  d);
    set_byte = hi ? {d, w[7:0]} : {w[15:8], d};
  endfunction : set_byte

  // Base count write following the counter's read/write mode
  function automatic logic [15:0] tmr_load(input logic [15:0] w,
                                           input logic [1:0]  rw,
                                           input logic        tog,
                                           input logic [7:0]  d);
    case (rw)
      2'b01:   tmr_load = set_byte(w, 1'b0, d);
      2'b10:   tmr_load = set_byte(w, 1'b1, d);
      2'b11:   tmr_load = set_byte(w, tog, d);
      default: tmr_load = w;
    endcase
  endfunction : tmr_load

  // ================================================================
  // Decode
  logic wr_pm_cmd, wr_pm_data, wr_ps_cmd, wr_ps_data;
  logic rd_pic, rd_t0, rd_t2;
  assign wr_pm_cmd  = io_wr && io_addr == `SRM_PORT_PIC_M_CMD;
  assign wr_pm_data = io_wr && io_addr == `SRM_PORT_PIC_M_DATA;
  assign wr_ps_cmd  = io_wr && io_addr == `SRM_PORT_PIC_S_CMD;
  assign wr_ps_data = io_wr && io_addr == `SRM_PORT_PIC_S_DATA;
  assign rd_pic     = io_rd && io_addr == `SRM_PORT_PIC_M_CMD;
  assign rd_t0      = io_rd && io_addr == `SRM_PORT_TMR0;
  assign rd_t2      = io_rd && io_addr == `SRM_PORT_TMR2;

  // ================================================================
  // Interrupt controller shadows
  logic [7:0] pic_word [12];

  srm_pic_shadow u_pic_m (
    .clk     (clk),
    .reset   (reset),
    .cmd_wr  (wr_pm_cmd),
    .data_wr (wr_pm_data),
    .wdata   (io_wdata),
    .iw2     (pic_word[0]),
    .iw3     (pic_word[1]),
    .iw4     (pic_word[2]),
    .ow1     (pic_word[3]),
    .ow2     (pic_word[4]),
    .ow3     (pic_word[5])
  );

  srm_pic_shadow u_pic_s (
    .clk     (clk),
    .reset   (reset),
    .cmd_wr  (wr_ps_cmd),
    .data_wr (wr_ps_data),
    .wdata   (io_wdata),
    .iw2     (pic_word[6]),
    .iw3     (pic_word[7]),
    .iw4     (pic_word[8]),
    .ow1     (pic_word[9]),
    .ow2     (pic_word[10]),
    .ow3     (pic_word[11])
  );

  // ================================================================
  // State
  logic        mode_ff, nxt_mode;
  logic [3:0]  pic_idx_ff, nxt_pic_idx;
  logic [2:0]  tmr_idx_ff, nxt_tmr_idx;
  logic [6:0]  rtc_idx_ff, nxt_rtc_idx;
  logic        nmi_en_ff, nxt_nmi_en;
  logic [5:0]  st0_ff, st2_ff, nxt_st0, nxt_st2;
  logic [15:0] base0_ff, base2_ff, nxt_base0, nxt_base2;
  logic        tog0_ff, tog2_ff, nxt_tog0, nxt_tog2;
  logic        tmr_read_ff, nxt_tmr_read;
  logic        fast_ff, nxt_fast;
  logic [23:0] tick_cnt_ff, nxt_tick_cnt;
  logic        tick_ff, nxt_tick;
  logic [15:0] dma_base_ff [NREG];
  logic [15:0] dma_cur_ff  [NREG];
  logic [15:0] nxt_dma_base [NREG];
  logic [15:0] nxt_dma_cur  [NREG];
  logic        byte_hi_ff, nxt_byte_hi;
  logic [7:0]  stat_lo_ff, stat_hi_ff, nxt_stat_lo, nxt_stat_hi;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        rd_valid_ff, nxt_rd_valid;
  logic        entering, leaving;
  logic [7:0]  rd_val;

  assign entering = nxt_mode && !mode_ff;
  assign leaving  = !nxt_mode && mode_ff;

  // ================================================================
  // Read answer; covered readback ports only claim while in the mode
  always_comb begin
    io_rd_claim = 1'b0;
    rd_val      = `SRM_RST_BYTE;
    if (io_addr == `SRM_PORT_SR_CTRL) begin
      io_rd_claim = 1'b1;
      rd_val      = {7'h00, mode_ff};
    end else if (io_addr == `SRM_PORT_PIC_M_CMD) begin
      io_rd_claim = mode_ff;
      rd_val      = pic_word[pic_idx_ff];
    end else if (io_addr == `SRM_PORT_TMR0) begin
      io_rd_claim = mode_ff;
      case (tmr_idx_ff)
        3'h0:    rd_val = {2'b00, st0_ff};
        3'h1:    rd_val = base0_ff[7:0];
        3'h2:    rd_val = base0_ff[15:8];
        3'h5:    rd_val = base2_ff[7:0];
        3'h6:    rd_val = base2_ff[15:8];
        default: rd_val = `SRM_RST_BYTE;
      endcase
    end else if (io_addr == `SRM_PORT_TMR2) begin
      io_rd_claim = mode_ff;
      rd_val      = {2'b00, st2_ff};
    end else if (io_addr == `SRM_PORT_RTC_IDX) begin
      io_rd_claim = 1'b1;
      rd_val      = {mode_ff & nmi_en_ff, rtc_idx_ff};
    end else if (io_addr == `SRM_PORT_DMA_STAT_LO) begin
      io_rd_claim = 1'b1;
      rd_val      = stat_lo_ff;
    end else if (io_addr == `SRM_PORT_DMA_STAT_HI) begin
      io_rd_claim = 1'b1;
      rd_val      = stat_hi_ff;
    end else if (io_addr < 16'(NREG)) begin
      io_rd_claim = 1'b1;
      rd_val      = byte_hi_ff ? dma_cur_ff[io_addr[2:0]][15:8]
                               : dma_cur_ff[io_addr[2:0]][7:0];
    end
  end

  // ================================================================
  // Next state
  always_comb begin
    nxt_mode     = mode_ff;
    nxt_pic_idx  = pic_idx_ff;
    nxt_tmr_idx  = tmr_idx_ff;
    nxt_rtc_idx  = rtc_idx_ff;
    nxt_nmi_en   = nmi_en_ff;
    nxt_st0      = st0_ff;
    nxt_st2      = st2_ff;
    nxt_base0    = base0_ff;
    nxt_base2    = base2_ff;
    nxt_tog0     = tog0_ff;
    nxt_tog2     = tog2_ff;
    nxt_tmr_read = tmr_read_ff;
    nxt_fast     = fast_ff;
    nxt_tick_cnt = tick_cnt_ff + 24'h000001;
    nxt_tick     = 1'b0;
    nxt_dma_base = dma_base_ff;
    nxt_dma_cur  = dma_cur_ff;
    nxt_byte_hi  = byte_hi_ff;
    nxt_stat_lo  = stat_lo_ff;
    nxt_stat_hi  = stat_hi_ff;
    nxt_rdata    = rdata_ff;
    nxt_rd_valid = io_rd && io_rd_claim;

    if (io_wr && io_addr == `SRM_PORT_SR_CTRL) begin
      nxt_mode = io_wdata[`SRM_SR_CTRL_EN_BIT];
    end

    // Sequence pointers
    if (entering) begin
      nxt_pic_idx = 4'h0;
      nxt_tmr_idx = 3'h0;
    end else if (mode_ff) begin
      if (rd_pic) begin
        nxt_pic_idx = (pic_idx_ff == `SRM_PIC_SEQ_LAST) ? 4'h0
                    : pic_idx_ff + 4'h1;
      end
      if (rd_t0) begin
        nxt_tmr_idx = (tmr_idx_ff == `SRM_TMR_SEQ_LAST) ? 3'h0
                    : tmr_idx_ff + 3'h1;
      end
    end

    if (io_wr && io_addr == `SRM_PORT_RTC_IDX) begin
      nxt_rtc_idx = io_wdata[6:0];
      nxt_nmi_en  = io_wdata[`SRM_RTC_NMI_BIT];
    end

    // Timer control and base counts
    if (io_wr && io_addr == `SRM_PORT_TMR_CTRL && io_wdata[5:4] != 2'b00)
    begin
      case (io_wdata[`SRM_TMR_SEL_HI:`SRM_TMR_SEL_LO])
        2'b00: begin
          nxt_st0  = io_wdata[5:0];
          nxt_tog0 = 1'b0;
          nxt_fast = 1'b0;
        end
        2'b10: begin
          nxt_st2  = io_wdata[5:0];
          nxt_tog2 = 1'b0;
        end
        default: begin
          nxt_st0 = st0_ff;
        end
      endcase
    end
    if (io_wr && io_addr == `SRM_PORT_TMR0) begin
      nxt_base0 = tmr_load(base0_ff, st0_ff[5:4], tog0_ff, io_wdata);
      nxt_tog0  = (st0_ff[5:4] == 2'b11) ? !tog0_ff : 1'b0;
    end
    if (io_wr && io_addr == `SRM_PORT_TMR2) begin
      nxt_base2 = tmr_load(base2_ff, st2_ff[5:4], tog2_ff, io_wdata);
      nxt_tog2  = (st2_ff[5:4] == 2'b11) ? !tog2_ff : 1'b0;
    end

    // Timer readback disturbs the system tick once the mode is left
    if (mode_ff && (rd_t0 || rd_t2)) begin
      nxt_tmr_read = 1'b1;
    end
    if (leaving && (tmr_read_ff || rd_t0 || rd_t2)) begin
      nxt_fast     = 1'b1;
      nxt_tmr_read = 1'b0;
    end
    if (tick_cnt_ff >= (fast_ff ? 24'(FAST_TICK_CYC - 1)
                                : 24'(NORM_TICK_CYC - 1))) begin
      nxt_tick_cnt = 24'h000000;
      nxt_tick     = 1'b1;
    end

    // DMA address and count registers
    if (io_addr < 16'(NREG) && (io_wr || io_rd)) begin
      nxt_byte_hi = !byte_hi_ff;
      if (io_wr) begin
        nxt_dma_cur[io_addr[2:0]] =
          set_byte(dma_cur_ff[io_addr[2:0]], byte_hi_ff, io_wdata);
        if (!mode_ff) begin
          nxt_dma_base[io_addr[2:0]] =
            set_byte(dma_base_ff[io_addr[2:0]], byte_hi_ff, io_wdata);
        end
      end
    end
    if (io_wr && io_addr == `SRM_PORT_DMA_CLR_FF) begin
      nxt_byte_hi = 1'b0;
    end

    // Status: read outside the mode clears terminal counts, new events always win
    if (io_rd && io_addr == `SRM_PORT_DMA_STAT_LO && !mode_ff) begin
      nxt_stat_lo = stat_lo_ff & ~`SRM_DMA_TC_MASK;
    end
    if (io_rd && io_addr == `SRM_PORT_DMA_STAT_HI && !mode_ff) begin
      nxt_stat_hi = stat_hi_ff & ~`SRM_DMA_TC_MASK;
    end
    if (mode_ff && io_wr && io_addr == `SRM_PORT_DMA_STAT_LO) begin
      nxt_stat_lo = io_wdata;
    end
    if (mode_ff && io_wr && io_addr == `SRM_PORT_DMA_STAT_HI) begin
      nxt_stat_hi = io_wdata;
    end
    nxt_stat_lo = nxt_stat_lo | dma_status_lo_set;
    nxt_stat_hi = nxt_stat_hi | dma_status_hi_set;

    if (io_rd && io_rd_claim) begin
      nxt_rdata = rd_val;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_ff     <= 1'b0;
      pic_idx_ff  <= 4'h0;
      tmr_idx_ff  <= 3'h0;
      rtc_idx_ff  <= 7'h00;
      nmi_en_ff   <= 1'b0;
      st0_ff      <= 6'h00;
      st2_ff      <= 6'h00;
      base0_ff    <= `SRM_RST_WORD;
      base2_ff    <= `SRM_RST_WORD;
      tog0_ff     <= 1'b0;
      tog2_ff     <= 1'b0;
      tmr_read_ff <= 1'b0;
      fast_ff     <= 1'b0;
      tick_cnt_ff <= 24'h000000;
      tick_ff     <= 1'b0;
      for (int i = 0; i < NREG; i++) begin
        dma_base_ff[i] <= `SRM_RST_WORD;
        dma_cur_ff[i]  <= `SRM_RST_WORD;
      end
      byte_hi_ff  <= 1'b0;
      stat_lo_ff  <= `SRM_RST_BYTE;
      stat_hi_ff  <= `SRM_RST_BYTE;
      rdata_ff    <= `SRM_RST_BYTE;
      rd_valid_ff <= 1'b0;
    end else begin
      mode_ff     <= nxt_mode;
      pic_idx_ff  <= nxt_pic_idx;
      tmr_idx_ff  <= nxt_tmr_idx;
      rtc_idx_ff  <= nxt_rtc_idx;
      nmi_en_ff   <= nxt_nmi_en;
      st0_ff      <= nxt_st0;
      st2_ff      <= nxt_st2;
      base0_ff    <= nxt_base0;
      base2_ff    <= nxt_base2;
      tog0_ff     <= nxt_tog0;
      tog2_ff     <= nxt_tog2;
      tmr_read_ff <= nxt_tmr_read;
      fast_ff     <= nxt_fast;
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= nxt_tick;
      dma_base_ff <= nxt_dma_base;
      dma_cur_ff  <= nxt_dma_cur;
      byte_hi_ff  <= nxt_byte_hi;
      stat_lo_ff  <= nxt_stat_lo;
      stat_hi_ff  <= nxt_stat_hi;
      rdata_ff    <= nxt_rdata;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign io_rdata          = rdata_ff;
  assign io_rd_valid       = rd_valid_ff;
  assign save_restore_mode = mode_ff;
  assign sys_tick          = tick_ff;
  assign timer_fast        = fast_ff;
endmodule : srm_top
`default_nettype wire

// File: tb/srm_top_props.sv
// Concurrent checks on the save/restore readback ports
`default_nettype none
module srm_top_props #(
  parameter int unsigned DMA_CH        = 4,
  parameter int unsigned NORM_TICK_CYC = 40,
  parameter int unsigned FAST_TICK_CYC = 10
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  dma_status_lo_set,
  input wire logic [7:0]  dma_status_hi_set,
  input wire logic        io_rd_claim,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rd_valid,
  input wire logic        save_restore_mode,
  input wire logic        sys_tick,
  input wire logic        timer_fast
);
  timeunit 1ns;
  timeprecision 1ps;
  // ================================================================
  // Helpers
  logic rd_ok;
  logic mode_wr;
  assign rd_ok   = io_rd && io_rd_claim;
  assign mode_wr = io_wr && io_addr == 16'h00b4;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ================================================================
  // Assertions
  AST_RD_ANSWER: assert property (rd_ok |=> io_rd_valid)
    else $error("claimed read got no answer");
  AST_NO_STRAY_VALID: assert property (!rd_ok |=> !io_rd_valid)
    else $error("read answer without a claimed read");
  AST_PIC_CLAIM: assert property (io_rd && io_addr == 16'h0020
    |-> io_rd_claim == save_restore_mode)
    else $error("port 20 claim disagrees with the mode");
  AST_TMR_CLAIM: assert property (io_rd && (io_addr == 16'h0040
    || io_addr == 16'h0042) |-> io_rd_claim == save_restore_mode)
    else $error("timer port claim disagrees with the mode");
  AST_INDEX_CLAIM: assert property (io_rd && io_addr == 16'h0070
    |-> io_rd_claim)
    else $error("clock index read not claimed");
  AST_NMI_HIDDEN: assert property (io_rd && io_addr == 16'h0070
    && !save_restore_mode |=> io_rdata[7] == 1'b0)
    else $error("clock index bit 7 visible outside the mode");
  AST_TMR2_HIGH: assert property (io_rd && io_addr == 16'h0042
    && save_restore_mode |=> io_rdata[7:6] == 2'b00)
    else $error("counter 2 status upper bits not zero");
  AST_MODE_WRITE: assert property (mode_wr
    |=> save_restore_mode == $past(io_wdata[0]))
    else $error("mode bit did not follow the control write");
  AST_MODE_HOLD: assert property (!mode_wr
    |=> $stable(save_restore_mode))
    else $error("mode bit moved without a control write");
  AST_FAST_ON_EXIT: assert property ($rose(timer_fast)
    |-> !save_restore_mode && $past(save_restore_mode))
    else $error("fast tick set without a mode exit");

  cover property (rd_ok && io_addr == 16'h0020);
  cover property ($rose(save_restore_mode));
  cover property ($rose(timer_fast));
endmodule : srm_top_props

bind srm_top srm_top_props #(
  .DMA_CH        (DMA_CH),
  .NORM_TICK_CYC (NORM_TICK_CYC),
  .FAST_TICK_CYC (FAST_TICK_CYC)
) u_props (
  .clk(clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr),
  .io_rd(io_rd), .io_wdata(io_wdata),
  .dma_status_lo_set(dma_status_lo_set),
  .dma_status_hi_set(dma_status_hi_set), .io_rd_claim(io_rd_claim),
  .io_rdata(io_rdata), .io_rd_valid(io_rd_valid),
  .save_restore_mode(save_restore_mode), .sys_tick(sys_tick),
  .timer_fast(timer_fast)
);
`default_nettype wire

// File: tb/tb_legacy_register_save_restore_mode.sv
// Self-checking bench for the save/restore readback block
`default_nettype none
module tb_legacy_register_save_restore_mode;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NORM = 40;
  localparam int unsigned FAST = 10;
  logic        clk, reset, io_wr, io_rd, io_rd_claim, io_rd_valid;
  logic        save_restore_mode, sys_tick, timer_fast;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, dma_status_lo_set, dma_status_hi_set;
  logic [7:0]  pw [12];
  logic [7:0]  tw [4];
  int          n_mismatch = 0;
  int          samples_checked = 0;

  srm_top #(.DMA_CH(4), .NORM_TICK_CYC(NORM), .FAST_TICK_CYC(FAST)) uut (
    .clk(clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata),
    .dma_status_lo_set(dma_status_lo_set),
    .dma_status_hi_set(dma_status_hi_set), .io_rd_claim(io_rd_claim),
    .io_rdata(io_rdata), .io_rd_valid(io_rd_valid),
    .save_restore_mode(save_restore_mode), .sys_tick(sys_tick),
    .timer_fast(timer_fast));

  // ================================================================
  // Helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
  endtask : wr

  // Answer is registered on the taking edge and sampled 1 ns after it
  task automatic rd(input logic [15:0] a, output logic [7:0] v,
                    output logic k);
    @(posedge clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    #1;
    k = io_rd_claim;
    @(posedge clk);
    #1;
    io_rd = 1'b0;
    v = io_rdata;
    chk({7'h0, io_rd_valid}, {7'h0, k});
  endtask : rd

  task automatic tick_gap(output int n);
    n = 0;
    while (sys_tick !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sys_tick !== 1'b1 && n < 100);
  endtask : tick_gap

  function automatic logic [7:0] pic_exp(input int k, input logic [7:0] w);
    case (k % 6)
      0: return w & 8'hf8;
      2: return w & 8'h12;
      4: return w & 8'he7;
      5: return {1'b0, w[6], w[6], 2'b01, w[2:0]};
      default: return w;
    endcase
  endfunction : pic_exp

  function automatic logic [7:0] tmr_exp(input int k);
    case (k)
      0: return 8'h34;
      1: return tw[0];
      2: return tw[1];
      5: return tw[2];
      6: return tw[3];
      default: return 8'h00;
    endcase
  endfunction : tmr_exp

  task automatic tally_and_finish();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // ================================================================
  // Clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin : main
    logic [7:0] v, d, e, s;
    logic       k;
    int         i, j, p, n;
    reset = 1'b1;
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    dma_status_lo_set = 8'h00;
    dma_status_hi_set = 8'h00;
    void'($urandom(21059));
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    d = 8'($urandom());
    wr(16'h0070, d);
    rd(16'h0070, v, k);
    chk(v, {1'b0, d[6:0]});
    for (i = 0; i < 12; i++) pw[i] = 8'($urandom());
    for (i = 0; i < 2; i++) begin
      pw[6*i+4][4:3] = 2'b00;
      pw[6*i+5][4:3] = 2'b01;
      p = i * 128;
      wr(16'(32 + p), 8'h11);
      for (j = 0; j < 4; j++) wr(16'(33 + p), pw[6*i+j]);
      wr(16'(32 + p), pw[6*i+4]);
      wr(16'(32 + p), pw[6*i+5]);
    end
    rd(16'h0021, v, k);
    rd(16'h0020, v, k);
    chk({7'h0, k}, 8'h00);
    for (i = 0; i < 4; i++) tw[i] = 8'($urandom());
    wr(16'h0043, 8'h34);
    wr(16'h0040, tw[0]);
    wr(16'h0040, tw[1]);
    wr(16'h0043, 8'hb6);
    wr(16'h0042, tw[2]);
    wr(16'h0042, tw[3]);
    p = int'($urandom_range(7));
    wr(16'h000c, 8'h00);
    wr(16'(p), d);
    wr(16'(p), ~d);
    wr(16'h000c, 8'h00);
    rd(16'(p), v, k);
    chk(v, d);
    rd(16'(p), v, k);
    chk(v, ~d);
    wr(16'h00b4, 8'h01);
    chk({7'h0, save_restore_mode}, 8'h01);
    rd(16'h00b4, v, k);
    chk(v, 8'h01);
    for (i = 0; i < 13; i++) begin
      rd(16'h0020, v, k);
      chk(v, pic_exp(i % 12, pw[i % 12]));
    end
    for (i = 0; i < 8; i++) begin
      rd(16'h0040, v, k);
      chk((i % 7 == 0) ? (v & 8'h3f) : v, tmr_exp(i % 7));
    end
    rd(16'h0042, v, k);
    chk(v, 8'h36);
    d = 8'($urandom());
    wr(16'h0070, d);
    rd(16'h0070, v, k);
    chk(v, d);
    e = 8'($urandom());
    wr(16'h000c, 8'h00);
    wr(16'(p), e);
    wr(16'(p), ~e);
    wr(16'h0008, tw[0]);
    wr(16'h00d0, tw[1]);
    wr(16'h00b4, 8'h00);
    rd(16'h0040, v, k);
    chk({7'h0, k}, 8'h00);
    chk({7'h0, timer_fast}, 8'h01);
    wr(16'h000c, 8'h00);
    rd(16'(p), v, k);
    chk(v, e);
    rd(16'(p), v, k);
    chk(v, ~e);
    // Set inputs OR into both status registers for one cycle
    s = 8'($urandom());
    dma_status_lo_set = s;
    dma_status_hi_set = s;
    @(posedge clk);
    #1;
    dma_status_lo_set = 8'h00;
    dma_status_hi_set = 8'h00;
    rd(16'h0008, v, k);
    chk(v, tw[0] | s);
    rd(16'h00d0, v, k);
    chk(v, tw[1] | s);
    rd(16'h0008, v, k);
    chk(v, (tw[0] | s) & 8'hf0);
    tick_gap(n);
    tick_gap(n);
    chk(8'(n), 8'(FAST));
    wr(16'h0043, 8'h34);
    tick_gap(n);
    tick_gap(n);
    chk(8'(n), 8'(NORM));
    chk({7'h0, timer_fast}, 8'h00);
    wr(16'h00b4, 8'h01);
    rd(16'h0020, v, k);
    chk(v, pic_exp(0, pw[0]));
    tally_and_finish();
  end
endmodule : tb_legacy_register_save_restore_mode
`default_nettype wire
